// file: src/ata_read_engine.sv
// Purpose: read-family command interpreter behind an AHB-Lite task file
// Assumes: media answers each sector request with 256 words then done
// Notes:   zero-wait slave; status read at index 7 clears the interrupt
`timescale 1ns/100ps
module ata_read_engine #(
    parameter int unsigned SECTORS_PER_TRACK = 32,
    parameter int unsigned HEAD_COUNT        = 16,
    parameter logic [27:0] LBA_LIMIT         = 28'h010_0000
) (
    input  wire logic                     CLK_I,
    input  wire logic                     RST_I,
    input  wire logic                     HSEL_I,
    input  wire logic [31:0]              HADDR_I,
    input  wire logic [1:0]               HTRANS_I,
    input  wire logic                     HWRITE_I,
    input  wire logic [2:0]               HSIZE_I,
    input  wire logic [31:0]              HWDATA_I,
    input  wire logic                     HREADY_I,
    output logic      [31:0]              HRDATA_O,
    output logic                          HREADYOUT_O,
    output logic                          HRESP_O,
    output logic                          INTRQ_O,
    output logic                          MEDIA_REQ_O,
    output logic      [27:0]              MEDIA_ADDR_O,
    output logic                          MEDIA_LBA_O,
    input  wire logic                     MEDIA_WORD_VALID_I,
    input  wire logic [15:0]              MEDIA_WORD_I,
    input  wire logic                     MEDIA_DONE_I,
    input  wire ata_rd_pkg::media_stat_t  MEDIA_STAT_I
);
    import ata_rd_pkg::*;

    state_t      st_q;
    mode_t       mode_q;
    logic [7:0]  feat_q, seccnt_q, secnum_q, cyllo_q, cylhi_q, dh_q;
    logic [7:0]  err_q, ext_q, blk_size_q;
    logic        multi_en_q, bsy_q, drq_q, err_st_q, corr_q, intrq_q;
    logic        freeze_q, stop_q, sec_bad_q, blk_first_q, media_req_q;
    logic [8:0]  left_q, blk_left_q;
    logic [27:0] cur_q;
    logic [15:0] buf_q [256];
    logic [7:0]  wptr_q, rptr_q;
    logic [31:0] rdata_q;
    logic        wr_q;
    logic [3:0]  widx_q;
    logic        intrq_d;

    function automatic logic [27:0] next_addr(input logic logical_addressing_select, input logic [27:0] a);
        logic [27:0] n;
        n = a + 28'h000_0001;
        if (!logical_addressing_select) begin
            n = a;
            if (a[7:0] == 8'(SECTORS_PER_TRACK)) begin
                n[7:0] = 8'h01;
                if (a[27:24] == 4'(HEAD_COUNT - 1)) begin
                    n[27:24] = 4'h0;
                    n[23:8]  = a[23:8] + 16'h0001;
                end else begin
                    n[27:24] = a[27:24] + 4'h1;
                end
            end else begin
                n[7:0] = a[7:0] + 8'h01;
            end
        end
        return n;
    endfunction

    function automatic logic [7:0] check_addr(input logic logical_addressing_select, input logic [27:0] a);
        logic [7:0] c;
        c = EXT_NONE;
        if (logical_addressing_select) begin
            if (a >= LBA_LIMIT) begin
                c = EXT_OVERFLOW;
            end
        end else if (a[7:0] == 8'h00 || a[7:0] > 8'(SECTORS_PER_TRACK)
                     || 32'(a[27:24]) >= HEAD_COUNT) begin
            c = EXT_BAD_ADDR;
        end
        return c;
    endfunction

    // bus decode
    wire logic       a_sel   = HSEL_I & HTRANS_I[1] & HREADY_I;
    wire logic [3:0] a_idx   = HADDR_I[5:2];
    wire logic       a_ok    = (HADDR_I[31:6] == 26'h000_0000) && (HADDR_I[1:0] == 2'b00)
                               && (a_idx <= IDX_MULTI);
    wire logic       rd_ev   = a_sel & ~HWRITE_I & a_ok;
    wire logic       data_rd = rd_ev & (a_idx == IDX_DATA) & drq_q;
    wire logic       stat_rd = rd_ev & (a_idx == IDX_COMMAND);
    wire logic       idle    = (st_q == S_IDLE);
    wire logic       tf_wr   = wr_q & idle;
    wire logic [7:0] wbyte   = HWDATA_I[7:0];
    wire logic       cmd_wr  = tf_wr & (widx_q == IDX_COMMAND);

    // command decode
    wire logic       c_multi  = (wbyte == CMD_READ_MULTI);
    wire logic       c_read   = (wbyte == CMD_READ_SEC) | (wbyte == CMD_READ_SEC_N);
    wire logic       c_verify = (wbyte == CMD_VERIFY) | (wbyte == CMD_VERIFY_N);
    wire logic       c_sense  = (wbyte == CMD_SENSE);
    wire logic       c_recal  = (wbyte[7:4] == CMD_RECAL_HI);
    wire logic       lba_mode = dh_q[DH_LBA];
    wire logic [27:0] st_addr = {dh_q[3:0], cylhi_q, cyllo_q, secnum_q};
    wire logic [7:0] a_code   = check_addr(lba_mode, st_addr);
    wire logic       multi_ok = multi_en_q & (blk_size_q != 8'h00);
    wire logic       c_media  = c_read | c_verify | (c_multi & multi_ok);
    wire logic       go       = cmd_wr & c_media & (a_code == EXT_NONE);
    wire logic       abort    = cmd_wr & ~go & ~c_sense & ~c_recal;
    wire logic [7:0] ab_code  = (c_media && a_code != EXT_NONE) ? a_code : EXT_ABORT;
    wire logic [8:0] st_cnt   = (seccnt_q == 8'h00) ? CNT_FULL : {1'b0, seccnt_q};
    wire logic [8:0] blk_full = {1'b0, blk_size_q};
    wire logic [8:0] first_blk = (blk_full < st_cnt) ? blk_full : st_cnt;

    // sector progress
    wire logic       f_done   = (st_q == S_FETCH) & MEDIA_DONE_I;
    wire logic       f_bad    = (MEDIA_STAT_I == MEDIA_UNCORR);
    wire logic       f_corr   = (MEDIA_STAT_I == MEDIA_CORR);
    wire logic       s_end    = (st_q == S_XFER) & data_rd & (rptr_q == LAST_WORD);
    wire logic       last_one = (left_q == 9'h001);
    wire logic       end_cmd  = last_one | ((mode_q == M_READ) & sec_bad_q)
                                | ((mode_q == M_MULTI) & stop_q & (blk_left_q == 9'h001));
    wire logic [27:0] nxt     = next_addr(lba_mode, cur_q);
    wire logic [8:0] left_n   = left_q - 9'h001;
    wire logic       blk_end  = (blk_left_q == 9'h001);
    wire logic [8:0] blk_nxt  = blk_end ? ((blk_full < left_n) ? blk_full : left_n)
                                        : blk_left_q - 9'h001;
    wire logic       v_fin    = f_done & (mode_q == M_VERIFY) & (f_bad | last_one);
    wire logic       x_irq    = f_done & (mode_q != M_VERIFY)
                                & ((mode_q != M_MULTI) | blk_first_q);
    wire logic       irq_set  = x_irq | v_fin | abort | (cmd_wr & (c_sense | c_recal));
    wire logic [7:0] status   = {bsy_q, 1'b1, 2'b00, drq_q, corr_q, 1'b0, err_st_q};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (a_idx == IDX_DATA) begin
            rd_mux = drq_q ? {16'h0000, buf_q[rptr_q]} : 32'h0000_0000;
        end else if (a_idx == IDX_FEATURE) begin
            rd_mux = {24'h00_0000, feat_q};
        end else if (a_idx == IDX_SECCNT) begin
            rd_mux = {24'h00_0000, seccnt_q};
        end else if (a_idx == IDX_SECNUM) begin
            rd_mux = {24'h00_0000, secnum_q};
        end else if (a_idx == IDX_CYLLO) begin
            rd_mux = {24'h00_0000, cyllo_q};
        end else if (a_idx == IDX_CYLHI) begin
            rd_mux = {24'h00_0000, cylhi_q};
        end else if (a_idx == IDX_DRVHEAD) begin
            rd_mux = {24'h00_0000, dh_q};
        end else if (a_idx == IDX_COMMAND || a_idx == IDX_ALTSTAT) begin
            rd_mux = {24'h00_0000, status};
        end else if (a_idx == IDX_ERROR) begin
            rd_mux = {24'h00_0000, err_q};
        end else if (a_idx == IDX_MULTI) begin
            rd_mux = {23'h00_0000, multi_en_q, blk_size_q};
        end
    end

    // set wins over the status-read clear
    assign intrq_d = irq_set | (intrq_q & ~stat_rd);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wr_q    <= 1'b0;
            widx_q  <= 4'h0;
            rdata_q <= 32'h0000_0000;
            intrq_q <= 1'b0;
        end else begin
            wr_q    <= a_sel & HWRITE_I & a_ok;
            widx_q  <= a_idx;
            rdata_q <= rd_ev ? rd_mux : 32'h0000_0000;
            intrq_q <= intrq_d;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (MEDIA_WORD_VALID_I && st_q == S_FETCH) begin
            buf_q[wptr_q] <= MEDIA_WORD_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_q <= S_IDLE;
            mode_q <= M_READ;
            feat_q <= 8'h00;
            seccnt_q <= RST_SECCNT;
            secnum_q <= RST_SECNUM;
            cyllo_q <= 8'h00;
            cylhi_q <= 8'h00;
            dh_q <= RST_DRVHEAD;
            err_q <= 8'h00;
            ext_q <= EXT_NONE;
            blk_size_q <= 8'h00;
            multi_en_q <= 1'b0;
            bsy_q <= 1'b0;
            drq_q <= 1'b0;
            err_st_q <= 1'b0;
            corr_q <= 1'b0;
            freeze_q <= 1'b0;
            stop_q <= 1'b0;
            sec_bad_q <= 1'b0;
            blk_first_q <= 1'b0;
            media_req_q <= 1'b0;
            left_q <= 9'h000;
            blk_left_q <= 9'h000;
            cur_q <= 28'h000_0000;
            wptr_q <= 8'h00;
            rptr_q <= 8'h00;
        end else begin
            if (tf_wr && widx_q == IDX_FEATURE) feat_q <= wbyte;
            if (tf_wr && widx_q == IDX_SECCNT) seccnt_q <= wbyte;
            if (tf_wr && widx_q == IDX_SECNUM) secnum_q <= wbyte;
            if (tf_wr && widx_q == IDX_CYLLO) cyllo_q <= wbyte;
            if (tf_wr && widx_q == IDX_CYLHI) cylhi_q <= wbyte;
            if (tf_wr && widx_q == IDX_DRVHEAD) dh_q <= wbyte;
            if (tf_wr && widx_q == IDX_MULTI) begin
                blk_size_q <= wbyte;
                multi_en_q <= HWDATA_I[MULTI_EN];
            end
            if (MEDIA_WORD_VALID_I && st_q == S_FETCH) wptr_q <= wptr_q + 8'h01;
            if (data_rd) rptr_q <= rptr_q + 8'h01;
            case (st_q)
                S_IDLE: begin
                    if (go) begin
                        mode_q <= c_multi ? M_MULTI : (c_verify ? M_VERIFY : M_READ);
                        bsy_q <= 1'b1;
                        err_st_q <= 1'b0;
                        corr_q <= 1'b0;
                        err_q <= 8'h00;
                        ext_q <= EXT_NONE;
                        freeze_q <= 1'b0;
                        stop_q <= 1'b0;
                        cur_q <= st_addr;
                        left_q <= st_cnt;
                        blk_left_q <= first_blk;
                        blk_first_q <= 1'b1;
                        media_req_q <= 1'b1;
                        wptr_q <= 8'h00;
                        st_q <= S_FETCH;
                    end else if (abort) begin
                        err_st_q <= 1'b1;
                        err_q <= 8'h00;
                        err_q[ER_ABRT] <= 1'b1;
                        err_q[ER_IDNF] <= (ab_code != EXT_ABORT);
                        ext_q <= ab_code;
                    end else if (cmd_wr && c_sense) begin
                        err_q <= ext_q;
                        ext_q <= EXT_NONE;
                        err_st_q <= 1'b0;
                    end else if (cmd_wr && c_recal) begin
                        err_st_q <= 1'b0;
                        err_q <= 8'h00;
                        ext_q <= EXT_NONE;
                    end
                end
                S_FETCH: begin
                    if (f_done) begin
                        media_req_q <= 1'b0;
                        sec_bad_q <= f_bad;
                        if (f_bad) begin
                            err_st_q <= 1'b1;
                            err_q[ER_UNC] <= 1'b1;
                            ext_q <= EXT_UNCORR;
                            freeze_q <= 1'b1;
                            stop_q <= 1'b1;
                        end else if (f_corr) begin
                            corr_q <= 1'b1;
                            if (ext_q == EXT_NONE) ext_q <= EXT_CORR;
                        end
                        if (mode_q == M_VERIFY) begin
                            if (f_bad) begin
                                seccnt_q <= left_q[7:0];
                                bsy_q <= 1'b0;
                                st_q <= S_IDLE;
                            end else if (last_one) begin
                                bsy_q <= 1'b0;
                                st_q <= S_IDLE;
                            end else begin
                                cur_q <= nxt;
                                {dh_q[3:0], cylhi_q, cyllo_q, secnum_q} <= nxt;
                                left_q <= left_n;
                                media_req_q <= 1'b1;
                                wptr_q <= 8'h00;
                            end
                        end else begin
                            drq_q <= 1'b1;
                            bsy_q <= 1'b0;
                            rptr_q <= 8'h00;
                            st_q <= S_XFER;
                        end
                    end
                end
                S_XFER: begin
                    if (s_end) begin
                        drq_q <= 1'b0;
                        if (end_cmd) begin
                            st_q <= S_IDLE;
                        end else begin
                            bsy_q <= 1'b1;
                            cur_q <= nxt;
                            if (!freeze_q) begin
                                {dh_q[3:0], cylhi_q, cyllo_q, secnum_q} <= nxt;
                            end
                            left_q <= left_n;
                            blk_left_q <= blk_nxt;
                            blk_first_q <= blk_end;
                            media_req_q <= 1'b1;
                            wptr_q <= 8'h00;
                            st_q <= S_FETCH;
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign HRDATA_O     = rdata_q;
    assign HREADYOUT_O  = 1'b1;
    assign HRESP_O      = 1'b0;
    assign INTRQ_O      = intrq_q;
    assign MEDIA_REQ_O  = media_req_q;
    assign MEDIA_ADDR_O = cur_q;
    assign MEDIA_LBA_O  = lba_mode;

    multi_irq_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        f_done && mode_q == M_MULTI && !blk_first_q && !intrq_q && !stat_rd |=> !intrq_q)
        else $error("interrupt inside a multiple block");
    drq_irq_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(drq_q) && (mode_q != M_MULTI || blk_first_q) |-> intrq_q && !bsy_q)
        else $error("data request without interrupt");
    count_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        go && seccnt_q == 8'h00 |=> left_q == 9'h100)
        else $error("zero count not taken as 256");
    verify_nodrq_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        mode_q == M_VERIFY |-> !drq_q)
        else $error("verify raised data request");
    verify_busy_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        go && c_verify |=> bsy_q && !idle)
        else $error("verify not busy at once");
    abort_multi_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        cmd_wr && idle && c_multi && !multi_ok |=> err_st_q && ext_q == 8'h1F && !bsy_q)
        else $error("multiple read not aborted");
    lba_split_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        go |=> MEDIA_ADDR_O == {$past(dh_q[3:0]), $past(cylhi_q), $past(cyllo_q),
                                $past(secnum_q)})
        else $error("address split wrong");
    sense_ret_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        cmd_wr && idle && c_sense |=> err_q == $past(ext_q) && ext_q == 8'h00)
        else $error("sense did not return code");
    verify_fail_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        f_done && mode_q == M_VERIFY && f_bad |=> seccnt_q == $past(left_q[7:0]) && idle)
        else $error("verify failure count wrong");
    recal_nop_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        cmd_wr && idle && c_recal |=> !bsy_q && !err_st_q && intrq_q && idle)
        else $error("recalibrate not a no-operation");
    word_count_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(drq_q) |-> rptr_q == 8'h00)
        else $error("sector pointer not rewound");

    multi_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        s_end && mode_q == M_MULTI && blk_end && !end_cmd);
    verify_c: cover property (@(posedge CLK_I) disable iff (RST_I) v_fin && !f_bad);
    read_err_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        f_done && f_bad && mode_q == M_READ);
endmodule

// file: pkg/ata_rd_pkg.sv
// Purpose: constants and types of the read command engine
// Assumes: one aligned 32-bit word per task-file register
// Notes:   byte address of a register is four times its index
package ata_rd_pkg;
    // register indices
    localparam logic [3:0] IDX_DATA    = 4'h0;
    localparam logic [3:0] IDX_FEATURE = 4'h1;
    localparam logic [3:0] IDX_SECCNT  = 4'h2;
    localparam logic [3:0] IDX_SECNUM  = 4'h3;
    localparam logic [3:0] IDX_CYLLO   = 4'h4;
    localparam logic [3:0] IDX_CYLHI   = 4'h5;
    localparam logic [3:0] IDX_DRVHEAD = 4'h6;
    localparam logic [3:0] IDX_COMMAND = 4'h7;
    localparam logic [3:0] IDX_ERROR   = 4'h8;
    localparam logic [3:0] IDX_ALTSTAT = 4'h9;
    localparam logic [3:0] IDX_MULTI   = 4'hA;
    // command codes
    localparam logic [7:0] CMD_READ_MULTI = 8'hC4;
    localparam logic [7:0] CMD_READ_SEC   = 8'h20;
    localparam logic [7:0] CMD_READ_SEC_N = 8'h21;
    localparam logic [7:0] CMD_VERIFY     = 8'h40;
    localparam logic [7:0] CMD_VERIFY_N   = 8'h41;
    localparam logic [7:0] CMD_SENSE      = 8'h03;
    localparam logic [3:0] CMD_RECAL_HI   = 4'h1;
    // extended error codes
    localparam logic [7:0] EXT_NONE     = 8'h00;
    localparam logic [7:0] EXT_BAD_ADDR = 8'h21;
    localparam logic [7:0] EXT_OVERFLOW = 8'h2F;
    localparam logic [7:0] EXT_ABORT    = 8'h1F;
    localparam logic [7:0] EXT_UNCORR   = 8'h11;
    localparam logic [7:0] EXT_CORR     = 8'h18;
    // status, error, drive/head and multiple register bit positions
    localparam int unsigned ST_BSY   = 7;
    localparam int unsigned ST_DRDY  = 6;
    localparam int unsigned ST_DRQ   = 3;
    localparam int unsigned ST_CORR  = 2;
    localparam int unsigned ST_ERR   = 0;
    localparam int unsigned ER_UNC   = 6;
    localparam int unsigned ER_IDNF  = 4;
    localparam int unsigned ER_ABRT  = 2;
    localparam int unsigned DH_LBA   = 6;
    localparam int unsigned MULTI_EN = 8;
    // reset values, full sector count and last word index
    localparam logic [7:0] RST_DRVHEAD = 8'hA0;
    localparam logic [7:0] RST_SECCNT  = 8'h01;
    localparam logic [7:0] RST_SECNUM  = 8'h01;
    localparam logic [8:0] CNT_FULL    = 9'h100;
    localparam logic [7:0] LAST_WORD   = 8'hFF;
    typedef enum logic [1:0] {
        MEDIA_OK,
        MEDIA_CORR,
        MEDIA_UNCORR,
        MEDIA_RSVD
    } media_stat_t;
    typedef enum {S_IDLE, S_FETCH, S_XFER} state_t;
    typedef enum {M_READ, M_MULTI, M_VERIFY} mode_t;
endpackage

// file: bench/media_model.sv
// Purpose: media side model answering sector requests
// Assumes: word is mixed low address bytes then word index
// Notes:   idle data lines show the inverted last word
`timescale 1ns/100ps
module media_model (
    input  wire logic                    clk_i,
    input  wire logic                    req_i,
    input  wire logic [27:0]             addr_i,
    input  wire logic [27:0]             bad_i,
    input  wire ata_rd_pkg::media_stat_t bad_stat_i,
    output logic                         valid_o,
    output logic [15:0]                  word_o,
    output logic                         done_o,
    output ata_rd_pkg::media_stat_t      stat_o
);
    import ata_rd_pkg::*;
    initial begin
        valid_o = 1'b0;
        word_o = 16'h0000;
        done_o = 1'b0;
        stat_o = MEDIA_RSVD;
        forever begin
            @(posedge clk_i);
            if (req_i) begin
                // odd sectors answer slowly
                repeat (addr_i[0] ? 9 : 2) @(posedge clk_i);
                for (int i = 0; i < 256; i++) begin
                    valid_o <= 1'b1;
                    word_o <= {addr_i[15:8] ^ addr_i[7:0], i[7:0]};
                    @(posedge clk_i);
                    valid_o <= 1'b0;
                    word_o <= ~word_o;
                    @(posedge clk_i);
                end
                done_o <= 1'b1;
                stat_o <= (addr_i == bad_i) ? bad_stat_i : MEDIA_OK;
                @(posedge clk_i);
                done_o <= 1'b0;
                stat_o <= MEDIA_RSVD;
            end
        end
    end
endmodule

// file: bench/test_ata_read_command_engine.sv
// Purpose: self-checking bench of the read command engine
// Assumes: media model answers every sector request
// Notes:   expected words come from an integer queue model
`timescale 1ns/100ps
module test_ata_read_command_engine;
    import ata_rd_pkg::*;
    logic        clk = 0, rst = 1, hsel = 1, hwrite = 0, hready, hresp, irq;
    logic        mreq, mlba, mval, mdone;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [27:0] maddr, bad = 28'hFFF_FFFF;
    logic [15:0] mword;
    media_stat_t mstat;
    int          fails = 0, checks_done = 0, cyc = 0, logical_addressing_select, exq[$];
    integer      seed = 32'h3cf0fca9;
    ata_read_engine dut (.CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .INTRQ_O(irq), .MEDIA_REQ_O(mreq), .MEDIA_ADDR_O(maddr), .MEDIA_LBA_O(mlba),
        .MEDIA_WORD_VALID_I(mval), .MEDIA_WORD_I(mword), .MEDIA_DONE_I(mdone),
        .MEDIA_STAT_I(mstat));
    media_model media (.clk_i(clk), .req_i(mreq), .addr_i(maddr), .bad_i(bad),
        .bad_stat_i(MEDIA_UNCORR), .valid_o(mval), .word_o(mword), .done_o(mdone),
        .stat_o(mstat));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] wd);
        @(posedge clk);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= 32'(idx) << 2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input string what, input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk(what, rd, exp);
    endtask
    task automatic done(input logic [31:0] st);
        for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
        chk("interrupt", 32'(irq), 32'h0000_0001);
        chk("response", 32'(hresp), 32'h0000_0000);
        rdc("status", IDX_COMMAND, st);
    endtask
    task automatic cmd(input int a, input logic [7:0] cnt, dh, c);
        bus(1'b1, IDX_SECCNT, 32'(cnt));
        bus(1'b1, IDX_SECNUM, 32'(a[7:0]));
        bus(1'b1, IDX_CYLLO, 32'(a[15:8]));
        bus(1'b1, IDX_CYLHI, 32'(a[23:16]));
        bus(1'b1, IDX_DRVHEAD, 32'(dh | a[27:24]));
        bus(1'b1, IDX_COMMAND, 32'(c));
    endtask
    task automatic sector(input int a);
        for (int i = 0; i < 256; i++)
            exq.push_back(((a & 255) ^ ((a >> 8) & 255)) * 256 + i);
        for (int i = 0; i < 256; i++) begin
            bus(1'b0, IDX_DATA, 32'h0000_0000);
            chk("data word", rd, 32'(exq.pop_front()));
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc("count reset", IDX_SECCNT, 32'h0000_0001);
        rdc("head reset", IDX_DRVHEAD, 32'h0000_00A0);
        rdc("unmapped", 4'hC, 32'h0000_0000);
        logical_addressing_select = $random(seed) & 32'h000F_FF00;
        for (int j = 0; j < 2; j++) begin
            cmd(logical_addressing_select, 8'(2 - j), 8'hE0, j ? CMD_READ_SEC_N : CMD_READ_SEC);
            for (int s = 0; s < 2 - j; s++) begin
                done(32'h0000_0048);
                sector(logical_addressing_select + s);
            end
            rdc("last sector", IDX_SECNUM, 32'(1 - j));
        end
        $display("test read done");
        bus(1'b1, IDX_MULTI, 32'h0000_0102);
        cmd(logical_addressing_select, 8'h03, 8'hE0, CMD_READ_MULTI);
        for (int s = 0; s < 3; s++) begin
            if (s == 1) begin
                rd = 32'h0000_0000;
                for (int k = 0; k < 900 && rd[3] !== 1'b1; k++)
                    bus(1'b0, IDX_ALTSTAT, 32'h0000_0000);
                chk("no sector irq", 32'(irq), 32'h0000_0000);
            end else
                done(32'h0000_0048);
            sector(logical_addressing_select + s);
        end
        $display("test multiple done");
        bus(1'b1, IDX_MULTI, 32'h0000_0000);
        for (int j = 0; j < 3; j++) begin
            cmd(j == 0 ? logical_addressing_select : j == 1 ? 0 : 32'h0010_0000, 8'h01, j == 1 ? 8'hA0 : 8'hE0,
                j == 0 ? CMD_READ_MULTI : CMD_READ_SEC);
            done(32'h0000_0041);
            chk("lba select", 32'(mlba), 32'(j != 1));
            cmd(logical_addressing_select, 8'h01, 8'hE0, CMD_SENSE);
            done(32'h0000_0040);
            rdc("sense", IDX_ERROR, j == 0 ? 32'h1F : j == 1 ? 32'h21 : 32'h2F);
        end
        cmd(logical_addressing_select, 8'h01, 8'hE0, {CMD_RECAL_HI, 4'($random(seed))});
        done(32'h0000_0040);
        $display("test abort done");
        bad = 28'(logical_addressing_select + 1);
        cmd(logical_addressing_select, 8'h03, 8'hE0, CMD_VERIFY_N);
        done(32'h0000_0041);
        rdc("fail sector", IDX_SECNUM, 32'h0000_0001);
        rdc("left count", IDX_SECCNT, 32'h0000_0002);
        bad = 28'hFFF_FFFF;
        cmd(logical_addressing_select, 8'h02, 8'hE0, CMD_VERIFY);
        done(32'h0000_0040);
        rdc("verified sector", IDX_SECNUM, 32'h0000_0001);
        $display("test verify done");
        results();
    end
endmodule
